// *** olpd_defs.svh ***
// constants for the eight-channel low-side pwm driver: offsets, widths, times
// assumes a 40 MHz core clock and a word-indexed plain register port
`ifndef OLPD_DEFS_SVH
`define OLPD_DEFS_SVH

`define OLPD_CLK_NS 25
`define OLPD_TICK_NS 250
`define OLPD_UPDATE_NS 125000
`define OLPD_TICK_DIV (`OLPD_TICK_NS / `OLPD_CLK_NS)
`define OLPD_UPDATE_CYCLES (`OLPD_UPDATE_NS / `OLPD_CLK_NS)

`define OLPD_NUM_CH 8
`define OLPD_CNT_W 24
`define OLPD_PEAK_W 8
`define OLPD_PEAK_SHIFT 6
`define OLPD_PEAK_CNT_W 14
`define OLPD_FIRST_PEAK_CH 4

`define OLPD_ADDR_W 8
`define OLPD_DATA_W 32
`define OLPD_ADDR_PERIOD 8'h00
`define OLPD_ADDR_ONTIME 8'h08
`define OLPD_ADDR_ENABLE 8'h10
`define OLPD_ADDR_PEAK 8'h11
`define OLPD_ADDR_STATUS 8'h12
`define OLPD_ADDR_CLEAR 8'h13
`define OLPD_CH_SEL_W 3
`define OLPD_BANK_MASK 8'hf8
`define OLPD_CLR_OPEN_LSB 0
`define OLPD_CLR_SHORT_LSB 8
`define OLPD_TICK_CNT_W 8
`define OLPD_UPD_CNT_W 16

`define OLPD_RST_SETTING 24'h000000
`define OLPD_RST_ENABLE 8'h00
`define OLPD_RST_PEAK 8'h00

`endif

// *** olpd_pkg.sv ***
// types shared by the pwm driver modules
// assumes olpd_defs.svh is on the include path
`include "olpd_defs.svh"
package olpd_pkg;
	typedef logic [`OLPD_CNT_W-1:0] olpd_ticks_t;
	typedef logic [`OLPD_NUM_CH-1:0] olpd_chvec_t;
	typedef logic [`OLPD_PEAK_CNT_W-1:0] olpd_peak_t;
endpackage

// *** olpd_chan_if.sv ***
// carrier between the register side and one pwm channel
// assumes one instance per channel, driven by olpd_top
import olpd_pkg::*;
interface olpd_chan_if;
	logic tick;
	logic enable;
	olpd_ticks_t cycle_length;
	olpd_ticks_t on_time;
	olpd_peak_t peak_ticks;
	logic use_peak;
	logic open_det;
	logic short_det;
	logic clr_open;
	logic clr_short;
	logic switch_on;
	logic peak_on;
	logic gen_on;
	logic open_flag;
	logic short_flag;
	modport ctl(output tick, enable, cycle_length, on_time, peak_ticks,
		use_peak, open_det, short_det, clr_open, clr_short,
		input switch_on, peak_on, gen_on, open_flag, short_flag);
	modport chan(input tick, enable, cycle_length, on_time, peak_ticks,
		use_peak, open_det, short_det, clr_open, clr_short,
		output switch_on, peak_on, gen_on, open_flag, short_flag);
endinterface

// *** olpd_chan.sv ***
// one pwm channel: counter, glitch-free command, fault flags, peak window
// assumes tick is a one-cycle pulse at 4 MHz and det inputs are synchronised
`include "olpd_defs.svh"
module olpd_chan
	import olpd_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	olpd_chan_if.chan ch
);
	olpd_ticks_t cnt_reg, cnt_next;
	logic expired_reg, expired_next;
	logic sw_reg, sw_next;
	logic peak_reg, peak_next;
	logic open_reg, open_next;
	logic short_reg, short_next;
	olpd_peak_t pk_reg, pk_next;
	logic wrap;
	logic cmd;

	always_comb begin
		// the counter runs only while enabled; disabled channels idle at zero
		wrap = ({1'b0, cnt_reg} + 25'h1) >= {1'b0, ch.cycle_length};
		cnt_next = cnt_reg;
		expired_next = expired_reg;
		if (!ch.enable) begin
			cnt_next = '0;
			expired_next = 1'b0;
		end else if (ch.tick) begin
			cnt_next = wrap ? '0 : cnt_reg + 24'h1;
			if (wrap)
				expired_next = 1'b0;
			else if (cnt_reg + 24'h1 >= ch.on_time)
				expired_next = 1'b1;
		end
		// closed from the cycle start until the on-time runs out
		if (!ch.enable || ch.on_time == '0)
			cmd = 1'b0;
		else if (ch.on_time >= ch.cycle_length)
			cmd = 1'b1;
		else
			cmd = !expired_reg && (cnt_reg < ch.on_time);

		// the open flag never feeds back into switching
		open_next = open_reg;
		if (ch.clr_open)
			open_next = 1'b0;
		if (!cmd && ch.open_det)
			open_next = 1'b1;

		short_next = short_reg;
		if (ch.clr_short && !cmd)
			short_next = 1'b0;
		if (cmd && ch.short_det)
			short_next = 1'b1;

		sw_next = cmd && !short_next;

		// peak window restarts on every closure, counted in 4 MHz ticks
		pk_next = pk_reg;
		if (sw_next && !sw_reg)
			pk_next = ch.peak_ticks;
		else if (!sw_next)
			pk_next = '0;
		else if (ch.tick && pk_reg != '0)
			pk_next = pk_reg - 14'h1;
		// hold through the cycle of the last tick: the window opens between
		// two ticks, so stopping at pk_next alone would lose one clock
		peak_next = ch.use_peak && sw_next
			&& (pk_reg != '0 || pk_next != '0);
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_reg <= '0;
			expired_reg <= 1'b0;
			sw_reg <= 1'b0;
			peak_reg <= 1'b0;
			open_reg <= 1'b0;
			short_reg <= 1'b0;
			pk_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
			expired_reg <= expired_next;
			sw_reg <= sw_next;
			peak_reg <= peak_next;
			open_reg <= open_next;
			short_reg <= short_next;
			pk_reg <= pk_next;
		end
	end

	assign ch.switch_on = sw_reg;
	assign ch.peak_on = peak_reg;
	assign ch.gen_on = cmd;
	assign ch.open_flag = open_reg;
	assign ch.short_flag = short_reg;
endmodule

// *** olpd_top.sv ***
// eight-channel low-side pwm driver with register port and fault flags
// assumes det pins are asynchronous to core_clk_i; register port is local
//
// Added by the designer: the strobed register port and the address map.
`include "olpd_defs.svh"
module olpd_top
	import olpd_pkg::*;
#(
	parameter int UPDATE_CYCLES = `OLPD_UPDATE_CYCLES,
	parameter int TICK_DIV = `OLPD_TICK_DIV
)
(
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic [`OLPD_ADDR_W-1:0] addr_i,
	input wire logic [`OLPD_DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [`OLPD_DATA_W-1:0] rdata_o,
	input wire logic [`OLPD_NUM_CH-1:0] open_det_i,
	input wire logic [`OLPD_NUM_CH-1:0] short_det_i,
	output logic [`OLPD_NUM_CH-1:0] switch_on_o,
	output logic [`OLPD_NUM_CH-1:0] peak_on_o
);
	olpd_ticks_t cyc_sh_reg [`OLPD_NUM_CH];
	olpd_ticks_t cyc_sh_next [`OLPD_NUM_CH];
	olpd_ticks_t on_sh_reg [`OLPD_NUM_CH];
	olpd_ticks_t on_sh_next [`OLPD_NUM_CH];
	olpd_ticks_t cyc_act_reg [`OLPD_NUM_CH];
	olpd_ticks_t cyc_act_next [`OLPD_NUM_CH];
	olpd_ticks_t on_act_reg [`OLPD_NUM_CH];
	olpd_ticks_t on_act_next [`OLPD_NUM_CH];
	olpd_chvec_t en_sh_reg, en_sh_next, en_act_reg, en_act_next;
	logic [`OLPD_PEAK_W-1:0] pk_sh_reg, pk_sh_next, pk_act_reg, pk_act_next;
	olpd_chvec_t clr_open_reg, clr_open_next, clr_short_reg, clr_short_next;
	logic [`OLPD_DATA_W-1:0] rdata_reg, rdata_next;
	localparam int TICK_W = `OLPD_TICK_CNT_W;
	localparam int UPD_W = `OLPD_UPD_CNT_W;
	localparam int DATA_W = `OLPD_DATA_W;
	localparam int NCH = `OLPD_NUM_CH;
	localparam int CLR_OP = `OLPD_CLR_OPEN_LSB;
	localparam int CLR_SH = `OLPD_CLR_SHORT_LSB;
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);
	localparam logic [UPD_W-1:0] UPD_LAST = UPD_W'(UPDATE_CYCLES - 1);
	logic [UPD_W-1:0] upd_cnt_reg, upd_cnt_next;
	logic [TICK_W-1:0] tick_cnt_reg, tick_cnt_next;
	logic tick_reg, tick_next;
	olpd_chvec_t open_s1_reg, open_s2_reg, short_s1_reg, short_s2_reg;
	olpd_chvec_t sw_vec, pk_vec, gen_vec, open_vec, short_vec;
	logic upd;
	logic [`OLPD_CH_SEL_W-1:0] sel;

	// two-stage synchronisers; only the second stage feeds the channels
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			open_s1_reg <= '0;
			open_s2_reg <= '0;
			short_s1_reg <= '0;
			short_s2_reg <= '0;
		end else begin
			open_s1_reg <= open_det_i;
			open_s2_reg <= open_s1_reg;
			short_s1_reg <= short_det_i;
			short_s2_reg <= short_s1_reg;
		end
	end

	// 4 MHz step derived from the core clock, one pulse per step
	always_comb begin
		tick_next = tick_cnt_reg == TICK_LAST;
		tick_cnt_next = tick_next ? '0 : tick_cnt_reg + TICK_W'(1);
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tick_cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			tick_cnt_reg <= tick_cnt_next;
			tick_reg <= tick_next;
		end
	end

	// frame timer standing in for the periodic serial update
	always_comb begin
		upd = upd_cnt_reg == UPD_LAST;
		upd_cnt_next = upd ? '0 : upd_cnt_reg + UPD_W'(1);
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			upd_cnt_reg <= '0;
		else
			upd_cnt_reg <= upd_cnt_next;
	end

	// write side: shadow settings and one-cycle clear pulses
	always_comb begin
		sel = addr_i[`OLPD_CH_SEL_W-1:0];
		cyc_sh_next = cyc_sh_reg;
		on_sh_next = on_sh_reg;
		en_sh_next = en_sh_reg;
		pk_sh_next = pk_sh_reg;
		clr_open_next = '0;
		clr_short_next = '0;
		if (wr_i) begin
			if ((addr_i & `OLPD_BANK_MASK) == `OLPD_ADDR_PERIOD)
				cyc_sh_next[sel] = wdata_i[`OLPD_CNT_W-1:0];
			if ((addr_i & `OLPD_BANK_MASK) == `OLPD_ADDR_ONTIME)
				on_sh_next[sel] = wdata_i[`OLPD_CNT_W-1:0];
			if (addr_i == `OLPD_ADDR_ENABLE)
				en_sh_next = wdata_i[`OLPD_NUM_CH-1:0];
			if (addr_i == `OLPD_ADDR_PEAK)
				pk_sh_next = wdata_i[`OLPD_PEAK_W-1:0];
			if (addr_i == `OLPD_ADDR_CLEAR) begin
				clr_open_next = wdata_i[CLR_OP +: NCH];
				clr_short_next = wdata_i[CLR_SH +: NCH];
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < `OLPD_NUM_CH; i++) begin
				cyc_sh_reg[i] <= `OLPD_RST_SETTING;
				on_sh_reg[i] <= `OLPD_RST_SETTING;
			end
			en_sh_reg <= `OLPD_RST_ENABLE;
			pk_sh_reg <= `OLPD_RST_PEAK;
			clr_open_reg <= '0;
			clr_short_reg <= '0;
		end else begin
			cyc_sh_reg <= cyc_sh_next;
			on_sh_reg <= on_sh_next;
			en_sh_reg <= en_sh_next;
			pk_sh_reg <= pk_sh_next;
			clr_open_reg <= clr_open_next;
			clr_short_reg <= clr_short_next;
		end
	end

	// settings take effect only on the periodic update, as if received
	// over the serial frame; a write between updates waits for the next
	always_comb begin
		cyc_act_next = cyc_act_reg;
		on_act_next = on_act_reg;
		en_act_next = en_act_reg;
		pk_act_next = pk_act_reg;
		if (upd) begin
			cyc_act_next = cyc_sh_reg;
			on_act_next = on_sh_reg;
			en_act_next = en_sh_reg;
			pk_act_next = pk_sh_reg;
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < `OLPD_NUM_CH; i++) begin
				cyc_act_reg[i] <= `OLPD_RST_SETTING;
				on_act_reg[i] <= `OLPD_RST_SETTING;
			end
			en_act_reg <= `OLPD_RST_ENABLE;
			pk_act_reg <= `OLPD_RST_PEAK;
		end else begin
			cyc_act_reg <= cyc_act_next;
			on_act_reg <= on_act_next;
			en_act_reg <= en_act_next;
			pk_act_reg <= pk_act_next;
		end
	end

	// read side: data stands only in the cycle after the strobe, else zero
	always_comb begin
		rdata_next = '0;
		if (rd_i) begin
			if ((addr_i & `OLPD_BANK_MASK) == `OLPD_ADDR_PERIOD)
				rdata_next = DATA_W'(cyc_sh_reg[sel]);
			else if ((addr_i & `OLPD_BANK_MASK) == `OLPD_ADDR_ONTIME)
				rdata_next = DATA_W'(on_sh_reg[sel]);
			else if (addr_i == `OLPD_ADDR_ENABLE)
				rdata_next = DATA_W'(en_sh_reg);
			else if (addr_i == `OLPD_ADDR_PEAK)
				rdata_next = DATA_W'(pk_sh_reg);
			else if (addr_i == `OLPD_ADDR_STATUS)
				rdata_next = {gen_vec, sw_vec, short_vec, open_vec};
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			rdata_reg <= '0;
		else
			rdata_reg <= rdata_next;
	end

	// one more stage so every switch pin comes straight from a flop
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			switch_on_o <= '0;
			peak_on_o <= '0;
		end else begin
			switch_on_o <= sw_vec;
			peak_on_o <= pk_vec;
		end
	end

	assign rdata_o = rdata_reg;

	// one generator per channel, each fed its own length, on-time and enable; channels five to eight share the peak setting
	for (genvar g = 0; g < `OLPD_NUM_CH; g++) begin : g_ch
		olpd_chan_if ch_if();
		assign ch_if.tick = tick_reg;
		assign ch_if.enable = en_act_reg[g];
		assign ch_if.cycle_length = cyc_act_reg[g];
		assign ch_if.on_time = on_act_reg[g];
		assign ch_if.peak_ticks = {pk_act_reg, {`OLPD_PEAK_SHIFT{1'b0}}};
		assign ch_if.use_peak = (g >= `OLPD_FIRST_PEAK_CH);
		assign ch_if.open_det = open_s2_reg[g];
		assign ch_if.short_det = short_s2_reg[g];
		assign ch_if.clr_open = clr_open_reg[g];
		assign ch_if.clr_short = clr_short_reg[g];
		assign sw_vec[g] = ch_if.switch_on;
		assign pk_vec[g] = ch_if.peak_on;
		assign gen_vec[g] = ch_if.gen_on;
		assign open_vec[g] = ch_if.open_flag;
		assign short_vec[g] = ch_if.short_flag;
		olpd_chan u_chan (
			.core_clk_i(core_clk_i),
			.reset_n_i(reset_n_i),
			.ch(ch_if.chan)
		);
	end
endmodule

// *** olpd_load_model.sv ***
// load model: open and short detectors for the eight solenoid channels
// assumes fault masks come from the bench and switch commands from the dut
module olpd_load_model (
	input wire logic [7:0] switch_on_i,
	input wire logic [7:0] open_fault_i,
	input wire logic [7:0] short_fault_i,
	output logic [7:0] open_det_o,
	output logic [7:0] short_det_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// a broken wire only shows while the switch is open
	assign open_det_o = ~switch_on_i & open_fault_i;
	// a short to battery only shows while current flows
	assign short_det_o = switch_on_i & short_fault_i;
endmodule

// *** olpd_top_asserts.sv ***
// port checker for olpd_top, bound to every instance
// assumes word-indexed register port and the status layout of the design
`include "olpd_defs.svh"
module olpd_top_chk
	import olpd_pkg::*;
#(
	parameter int UPDATE_CYCLES = `OLPD_UPDATE_CYCLES,
	parameter int TICK_DIV = `OLPD_TICK_DIV
)
(
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic [`OLPD_ADDR_W-1:0] addr_i,
	input wire logic [`OLPD_DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [`OLPD_DATA_W-1:0] rdata_o,
	input wire logic [`OLPD_NUM_CH-1:0] open_det_i,
	input wire logic [`OLPD_NUM_CH-1:0] short_det_i,
	input wire logic [`OLPD_NUM_CH-1:0] switch_on_o,
	input wire logic [`OLPD_NUM_CH-1:0] peak_on_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic en_seen_reg;
	logic en_seen_next;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	// sticky: later disabling still leaves the flag set
	always_comb begin
		en_seen_next = en_seen_reg;
		if (wr_i && addr_i == `OLPD_ADDR_ENABLE && wdata_i[7:0] != 8'h00)
			en_seen_next = 1'b1;
	end
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			en_seen_reg <= 1'b0;
		else
			en_seen_reg <= en_seen_next;
	end
	rd_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
		else $error("read data not zero outside read");
	rd_unmap_a: assert property (rd_i && addr_i > `OLPD_ADDR_CLEAR
		|=> rdata_o == 32'h0) else $error("unmapped read not zero");
	rd_en_a: assert property (rd_i && addr_i == `OLPD_ADDR_ENABLE
		|=> rdata_o[31:8] == 24'h0) else $error("enable upper bits");
	rd_len_a: assert property (rd_i && addr_i < `OLPD_ADDR_ENABLE
		|=> rdata_o[31:24] == 8'h0) else $error("setting wider than 24");
	peak_low_a: assert property (peak_on_o[3:0] == 4'h0)
		else $error("peak window on channels one to four");
	peak_sw_a: assert property ((peak_on_o & ~switch_on_o) == 8'h00)
		else $error("peak window while switch open");
	idle_sw_a: assert property (!en_seen_reg |-> switch_on_o == 8'h0)
		else $error("switch closed while never enabled");
	idle_pk_a: assert property (!en_seen_reg |-> peak_on_o == 8'h0)
		else $error("peak window while never enabled");
	for (genvar i = 0; i < 8; i++) begin : g_sc
		short_cut_a: assert property (switch_on_o[i] && short_det_i[i]
			|-> ##[1:8] !switch_on_o[i]) else $error("short not cut");
	end
endmodule
bind olpd_top olpd_top_chk #(.UPDATE_CYCLES(UPDATE_CYCLES),
	.TICK_DIV(TICK_DIV)) i_chk (.core_clk_i, .reset_n_i, .addr_i,
	.wdata_i, .wr_i, .rd_i, .rdata_o, .open_det_i, .short_det_i,
	.switch_on_o, .peak_on_o);

// *** olpd_top_tb.sv ***
// self-checking bench for olpd_top with a load model on the detectors
// assumes shortened update and tick divisors so the run stays brief
`include "olpd_defs.svh"
module olpd_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import olpd_pkg::*;
	logic core_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o;
	olpd_chvec_t open_det_i, short_det_i, switch_on_o, peak_on_o;
	olpd_chvec_t open_flt = 8'h00;
	olpd_chvec_t short_flt = 8'h00;
	logic [31:0] cnt_sw [8];
	logic [31:0] cnt_pk [8];
	logic [31:0] on_tab [4] = '{32'd0, 32'd4, 32'd10, 32'd30};
	logic [31:0] sw_tab [4] = '{32'd0, 32'd160, 32'd400, 32'd400};
	int fail_count = 0;
	int comparisons = 0;
	always #12.5 core_clk_i = ~core_clk_i;
	olpd_top #(.UPDATE_CYCLES(20), .TICK_DIV(2)) i_dut (.core_clk_i,
		.reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.open_det_i, .short_det_i, .switch_on_o, .peak_on_o);
	olpd_load_model i_load (.switch_on_i(switch_on_o),
		.open_fault_i(open_flt), .short_fault_i(short_flt),
		.open_det_o(open_det_i), .short_det_o(short_det_i));
	task automatic chk(string what, logic [31:0] got, logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rdc(string w, logic [7:0] a, logic [31:0] m, e);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		@(negedge core_clk_i);
		chk(w, rdata_o & m, e);
	endtask
	// one window spans whole periods of every channel used
	task automatic measure();
		repeat (450) @(posedge core_clk_i);
		cnt_sw = '{default: 32'h0};
		cnt_pk = '{default: 32'h0};
		repeat (400) begin
			@(negedge core_clk_i);
			for (int i = 0; i < 8; i++) begin
				cnt_sw[i] += switch_on_o[i];
				cnt_pk[i] += peak_on_o[i];
			end
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		rdc("status", 8'h12, 32'hffffffff, 32'h0);
		rdc("enable", 8'h10, 32'hffffffff, 32'h0);
		wr(8'h00, 32'hff00000a);
		rdc("length", 8'h00, 32'hffffffff, 32'h0000000a);
		wr(8'h01, 32'd8);
		wr(8'h09, 32'd2);
		wr(8'h02, 32'd8);
		wr(8'h0a, 32'd4);
		wr(8'h04, 32'd200);
		wr(8'h0c, 32'd100);
		wr(8'h11, 32'h1);
		wr(8'h10, 32'h13);
		rdc("unmapped", 8'h20, 32'hffffffff, 32'h0);
		for (int k = 0; k < 4; k++) begin
			wr(8'h08, on_tab[k]);
			measure();
			chk("ch1 high", cnt_sw[0], sw_tab[k]);
			chk("ch2 high", cnt_sw[1], 32'd100);
			chk("ch3 high", cnt_sw[2], 32'd0);
			chk("ch5 high", cnt_sw[4], 32'd200);
			chk("ch5 peak", cnt_pk[4], 32'd128);
			chk("ch1 peak", cnt_pk[0], 32'd0);
		end
		wr(8'h08, 32'd4);
		open_flt <= 8'h01;
		measure();
		chk("open ch1 high", cnt_sw[0], 32'd160);
		rdc("open flag", 8'h12, 32'hffff, 32'h1);
		open_flt <= 8'h00;
		repeat (5) @(posedge core_clk_i);
		wr(8'h13, 32'h1);
		rdc("open clear", 8'h12, 32'hffff, 32'h0);
		short_flt <= 8'h01;
		measure();
		chk("short ch1 high", cnt_sw[0], 32'd0);
		rdc("short flag", 8'h12, 32'hff00, 32'h100);
		short_flt <= 8'h00;
		wr(8'h08, 32'd30);
		repeat (100) @(posedge core_clk_i);
		wr(8'h13, 32'h100); // a single clear, repeated below once the on-time is zero
		// flag kept, command still high, switch held open
		rdc("short held", 8'h12, 32'h01010100, 32'h01000100);
		wr(8'h08, 32'd0);
		repeat (100) @(posedge core_clk_i);
		wr(8'h13, 32'h100);
		rdc("short clear", 8'h12, 32'hff00, 32'h0);
		wr(8'h08, 32'd4);
		measure();
		chk("ch1 resumed", cnt_sw[0], 32'd160);
		summarize();
	end
	initial begin
		repeat (20000) @(posedge core_clk_i);
		fail_count++;
		summarize();
	end
endmodule
